// ===== verilog/tmc_consts.svh
// Constants for the timer module common core: access addresses, field codes and divider counts
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH

// Byte access addresses
`define TMC_ADDR_CNT_LOW 2'h0
`define TMC_ADDR_CNT_HIGH 2'h1
`define TMC_ADDR_CMPA_LOW 2'h2
`define TMC_ADDR_CMPA_HIGH 2'h3

// Field widths and positions
`define TMC_CNT_WIDTH 10
`define TMC_HIGH_LSB 8
`define TMC_HIGH_MSB 9
`define TMC_P_LSB 7

// Counter values
`define TMC_CNT_ZERO 10'h000
`define TMC_CNT_MAX 10'h3ff
`define TMC_P_LOW_ZERO 7'h00

// Reset values
`define TMC_CMPA_RESET 10'h000
`define TMC_BYTE_RESET 8'h00

// Output function codes
`define TMC_IO_NONE 2'h0
`define TMC_IO_LOW 2'h1
`define TMC_IO_HIGH 2'h2
`define TMC_IO_TOGGLE 2'h3

// Capture edge codes
`define TMC_CAP_RISE 2'h0
`define TMC_CAP_FALL 2'h1

// Divider terminal counts
`define TMC_DIV4_LAST 2'h3
`define TMC_DIV16_LAST 4'hf
`define TMC_DIV64_LAST 6'h3f
`define TMC_DIV64_ZERO 6'h00

`endif

// ===== verilog/tmc_pkg.sv
// Types for the timer module common core
package tmc_pkg;

  // Operating modes
  typedef enum logic [1:0] {
    TMC_MODE_COMPARE = 2'b00,
    TMC_MODE_CAPTURE = 2'b01,
    TMC_MODE_PWM = 2'b10,
    TMC_MODE_TIMER = 2'b11
  } tmc_mode_type;

  // Counter clock source codes
  typedef enum logic [2:0] {
    TMC_CLK_SYS_DIV4 = 3'b000,
    TMC_CLK_SYS = 3'b001,
    TMC_CLK_HIGH_DIV16 = 3'b010,
    TMC_CLK_HIGH_DIV64 = 3'b011,
    TMC_CLK_SUB_A = 3'b100,
    TMC_CLK_SUB_B = 3'b101,
    TMC_CLK_EXT_RISE = 3'b110,
    TMC_CLK_EXT_FALL = 3'b111
  } tmc_clk_sel_type;

  // Single pulse sequencer
  typedef enum logic {
    TMC_SP_IDLE = 1'b0,
    TMC_SP_RUN = 1'b1
  } tmc_sp_state_type;

endpackage : tmc_pkg

// ===== verilog/tmc_tick_gen.sv
// Counter tick generator: clock source selection, dividers and external pin edges
`timescale 1ns/1ps
`include "tmc_consts.svh"

module tmc_tick_gen (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [2:0] clock_source_select,
  input wire logic internal_high_clock,
  input wire logic sub_clock,
  input wire logic ext_clock_pin,
  output logic tick,
  output logic ext_rise,
  output logic ext_fall
);

  logic [1:0] sys_div_q;
  logic [5:0] high_div_q;
  logic ext_prev_q;
  logic sys_div4_tick;
  logic high_div16_tick;
  logic high_div64_tick;
  tmc_pkg::tmc_clk_sel_type sel;

  // Free dividers; the high clock arrives as a one-cycle enable
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sys_div_q <= 2'h0;
      high_div_q <= 6'h00;
      ext_prev_q <= 1'b0;
    end else begin
      sys_div_q <= sys_div_q + 2'h1;
      ext_prev_q <= ext_clock_pin;
      if (internal_high_clock) begin
        high_div_q <= high_div_q + 6'h01;
      end
    end
  end

  // Edge and divider decode
  assign sys_div4_tick = (sys_div_q == `TMC_DIV4_LAST);
  assign high_div16_tick = internal_high_clock && (high_div_q[3:0] == `TMC_DIV16_LAST);
  assign high_div64_tick = internal_high_clock && (high_div_q == `TMC_DIV64_LAST);
  assign ext_rise = ext_clock_pin && !ext_prev_q;
  assign ext_fall = !ext_clock_pin && ext_prev_q;
  assign sel = tmc_pkg::tmc_clk_sel_type'(clock_source_select);

  always_comb begin
    case (sel)
      tmc_pkg::TMC_CLK_SYS_DIV4: tick = sys_div4_tick;
      tmc_pkg::TMC_CLK_SYS: tick = 1'b1;
      tmc_pkg::TMC_CLK_HIGH_DIV16: tick = high_div16_tick;
      tmc_pkg::TMC_CLK_HIGH_DIV64: tick = high_div64_tick;
      tmc_pkg::TMC_CLK_SUB_A: tick = sub_clock;
      tmc_pkg::TMC_CLK_SUB_B: tick = sub_clock;
      tmc_pkg::TMC_CLK_EXT_RISE: tick = ext_rise;
      tmc_pkg::TMC_CLK_EXT_FALL: tick = ext_fall;
      default: tick = 1'b0;
    endcase
  end

endmodule : tmc_tick_gen

// ===== verilog/tmc_core.sv
// Timer module common core: counter, comparators, output pins, capture and byte access
`timescale 1ns/1ps
`include "tmc_consts.svh"

module tmc_core #(
  parameter bit STANDARD_TYPE = 1'b1
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic counter_enable_bit,
  input wire logic counter_pause,
  input wire logic [2:0] clock_source_select,
  input wire logic [2:0] compare_p_value,
  input wire logic [1:0] timer_mode,
  input wire logic [1:0] output_function,
  input wire logic output_initial_level,
  input wire logic output_polarity,
  input wire logic clear_on_a_match,
  input wire logic single_pulse_mode,
  input wire logic [1:0] capture_edge_select,
  input wire logic internal_high_clock,
  input wire logic sub_clock,
  input wire logic ext_clock_pin,
  input wire logic capture_input_pin,
  input wire logic byte_write,
  input wire logic byte_read,
  input wire logic [1:0] byte_addr,
  input wire logic [7:0] byte_wdata,
  output logic [7:0] byte_rdata,
  output logic match_a_irq,
  output logic match_p_irq,
  output logic timer_output_pin,
  output logic timer_output_inverted_pin
);

  localparam int CW = `TMC_CNT_WIDTH;

  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic [CW-1:0] compare_a_value_q;
  logic [7:0] hold_buf_q;
  logic [7:0] byte_rdata_q;
  logic enable_prev_q;
  logic capture_prev_q;
  logic level_q;
  logic match_a_q;
  logic match_p_q;
  tmc_pkg::tmc_sp_state_type sp_state_q;
  tmc_pkg::tmc_sp_state_type sp_state_d;

  logic tick;
  logic ext_rise;
  logic ext_fall;
  logic enable_rise;
  logic running;
  logic advance;
  logic [CW-1:0] count_inc;
  logic at_a;
  logic at_p;
  logic clear_now;
  logic becomes_a;
  logic becomes_p;
  logic cap_rise;
  logic cap_fall;
  logic capture_event;
  logic sp_trigger;
  logic wr_a_low;
  logic wr_a_high;
  logic rd_cnt_high;
  logic rd_a_high;
  logic rd_low;
  logic is_compare_mode;
  logic is_pwm_mode;
  logic is_capture_mode;
  logic pwm_level;
  logic level_d;

  // Clock source and external pin edges
  // Dividers run free, so the first tick after an enable may come early
  tmc_tick_gen i_tmc_tick_gen (
    .clock(clock),
    .resetn(resetn),
    .clock_source_select(clock_source_select),
    .internal_high_clock(internal_high_clock),
    .sub_clock(sub_clock),
    .ext_clock_pin(ext_clock_pin),
    .tick(tick),
    .ext_rise(ext_rise),
    .ext_fall(ext_fall)
  );

  // Mode decode
  assign is_compare_mode = (timer_mode == tmc_pkg::TMC_MODE_COMPARE);
  assign is_pwm_mode = (timer_mode == tmc_pkg::TMC_MODE_PWM);
  // Capture and single pulse vanish when the standard type is off
  assign is_capture_mode = STANDARD_TYPE && (timer_mode == tmc_pkg::TMC_MODE_CAPTURE);
  assign enable_rise = counter_enable_bit && !enable_prev_q;

  assign sp_trigger = STANDARD_TYPE && single_pulse_mode && counter_enable_bit && ext_rise;

  // Single pulse holds the counter until triggered; other modes run free when enabled and not paused
  assign running = counter_enable_bit && !counter_pause && (!single_pulse_mode || !STANDARD_TYPE ||
    (sp_state_q == tmc_pkg::TMC_SP_RUN));
  assign advance = running && tick;

  assign at_a = (count_q == compare_a_value_q);
  // A zero P field stands for the full count, so P then marks overflow
  assign at_p = (compare_p_value == 3'h0) ? (count_q == `TMC_CNT_MAX) :
    ((count_q[CW-1:`TMC_P_LSB] == compare_p_value) && (count_q[`TMC_P_LSB-1:0] == `TMC_P_LOW_ZERO));

  // match selected for clearing restarts from zero
  // Limitation: clearing on A with A at zero parks the count at zero
  assign clear_now = clear_on_a_match ? at_a : at_p;
  assign count_inc = clear_now ? `TMC_CNT_ZERO : count_q + 10'h001;

  // only the enable rise clears from outside
  always_comb begin
    if (enable_rise) begin
      count_d = `TMC_CNT_ZERO;
    end else if (advance) begin
      count_d = count_inc;
    end else begin
      count_d = count_q;
    end
  end

  // Gating on a change keeps a held or paused count from firing again
  // flag the cycle in which the count reaches the value
  assign becomes_a = (count_d != count_q || enable_rise) && (count_d == compare_a_value_q);
  assign becomes_p = (count_d != count_q || enable_rise) && (compare_p_value == 3'h0 ?
    (count_d == `TMC_CNT_MAX) :
    ((count_d[CW-1:`TMC_P_LSB] == compare_p_value) && (count_d[`TMC_P_LSB-1:0] == `TMC_P_LOW_ZERO)));

  assign cap_rise = capture_input_pin && !capture_prev_q;
  assign cap_fall = !capture_input_pin && capture_prev_q;
  always_comb begin
    case (capture_edge_select)
      `TMC_CAP_RISE: capture_event = cap_rise;
      `TMC_CAP_FALL: capture_event = cap_fall;
      default: capture_event = cap_rise || cap_fall;
    endcase
  end

  assign wr_a_low = byte_write && (byte_addr == `TMC_ADDR_CMPA_LOW);
  assign wr_a_high = byte_write && (byte_addr == `TMC_ADDR_CMPA_HIGH);
  assign rd_cnt_high = byte_read && (byte_addr == `TMC_ADDR_CNT_HIGH);
  assign rd_a_high = byte_read && (byte_addr == `TMC_ADDR_CMPA_HIGH);
  assign rd_low = byte_read && ((byte_addr == `TMC_ADDR_CNT_LOW) || (byte_addr == `TMC_ADDR_CMPA_LOW));

  // Counter, enable history and capture pin history
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count_q <= `TMC_CNT_ZERO;
      enable_prev_q <= 1'b0;
      capture_prev_q <= 1'b0;
    end else begin
      count_q <= count_d;
      enable_prev_q <= counter_enable_bit;
      capture_prev_q <= capture_input_pin;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      match_a_q <= 1'b0;
      match_p_q <= 1'b0;
    end else begin
      match_a_q <= counter_enable_bit && (becomes_a || (is_capture_mode && capture_event));
      match_p_q <= counter_enable_bit && becomes_p;
    end
  end
  assign match_a_irq = match_a_q;
  assign match_p_irq = match_p_q;

  // high write copies buffer; software write beats a capture in the same cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      compare_a_value_q <= `TMC_CMPA_RESET;
    end else if (wr_a_high) begin
      compare_a_value_q <= {byte_wdata[1:0], hold_buf_q};
    end else if (is_capture_mode && counter_enable_bit && capture_event) begin
      compare_a_value_q <= count_q;
    end
  end

  // buffer loads only on low write or high read
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hold_buf_q <= `TMC_BYTE_RESET;
    end else if (wr_a_low) begin
      hold_buf_q <= byte_wdata;
    end else if (rd_cnt_high) begin
      // counter high read latches low byte
      hold_buf_q <= count_q[7:0];
    end else if (rd_a_high) begin
      hold_buf_q <= compare_a_value_q[7:0];
    end
  end

  // Read data is registered; it shows one cycle after the read strobe
  // High bytes carry bits 9 and 8 only; the upper six bits read zero
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      byte_rdata_q <= `TMC_BYTE_RESET;
    end else if (rd_cnt_high) begin
      byte_rdata_q <= {6'h00, count_q[`TMC_HIGH_MSB:`TMC_HIGH_LSB]};
    end else if (rd_a_high) begin
      byte_rdata_q <= {6'h00, compare_a_value_q[`TMC_HIGH_MSB:`TMC_HIGH_LSB]};
    end else if (rd_low) begin
      byte_rdata_q <= hold_buf_q;
    end
  end
  assign byte_rdata = byte_rdata_q;

  // Single pulse sequencer: trigger starts, compare A match ends
  always_comb begin
    case (sp_state_q)
      tmc_pkg::TMC_SP_IDLE: sp_state_d = sp_trigger ? tmc_pkg::TMC_SP_RUN : tmc_pkg::TMC_SP_IDLE;
      tmc_pkg::TMC_SP_RUN: sp_state_d = (becomes_a || !counter_enable_bit) ? tmc_pkg::TMC_SP_IDLE :
        tmc_pkg::TMC_SP_RUN;
      default: sp_state_d = tmc_pkg::TMC_SP_IDLE;
    endcase
  end

  // Sequencer state register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sp_state_q <= tmc_pkg::TMC_SP_IDLE;
    end else begin
      sp_state_q <= sp_state_d;
    end
  end

  // edge-aligned PWM: active from zero until compare A
  // Codes 00 and 11 hold inactive, 01 holds active, only 10 runs the wave
  always_comb begin
    case (output_function)
      `TMC_IO_NONE: pwm_level = 1'b0;
      `TMC_IO_LOW: pwm_level = 1'b1;
      `TMC_IO_HIGH: pwm_level = (count_d < compare_a_value_q);
      default: pwm_level = 1'b0;
    endcase
  end

  // compare output action on an A match
  always_comb begin
    level_d = level_q;
    if (enable_rise) begin
      level_d = output_initial_level;
    end else if (STANDARD_TYPE && single_pulse_mode) begin
      level_d = (sp_state_d == tmc_pkg::TMC_SP_RUN);
    end else if (is_pwm_mode && counter_enable_bit) begin
      level_d = pwm_level;
    end else if (is_compare_mode && counter_enable_bit && becomes_a) begin
      case (output_function)
        `TMC_IO_LOW: level_d = 1'b0;
        `TMC_IO_HIGH: level_d = 1'b1;
        `TMC_IO_TOGGLE: level_d = !level_q;
        default: level_d = level_q;
      endcase
    end
  end

  // Level held in a flop so the pins never glitch on compare decode
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      level_q <= 1'b0;
    end else begin
      level_q <= level_d;
    end
  end

  assign timer_output_pin = level_q ^ output_polarity;
  assign timer_output_inverted_pin = !timer_output_pin;

endmodule : tmc_core

// ===== tb/tmc_core_monitor.sv
// Port checker for the timer core
`timescale 1ns/1ps
module tmc_core_monitor (
  input wire logic clock,
  input wire logic resetn,
  input wire logic counter_enable_bit,
  input wire logic output_initial_level,
  input wire logic output_polarity,
  input wire logic [1:0] timer_mode,
  input wire logic [1:0] output_function,
  input wire logic byte_read,
  input wire logic [1:0] byte_addr,
  input wire logic [7:0] byte_rdata,
  input wire logic match_a_irq,
  input wire logic match_p_irq,
  input wire logic timer_output_pin,
  input wire logic timer_output_inverted_pin
);
  default clocking mon_cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // Compare output mode decode
  wire cmp_mode = timer_mode == 2'h0;

  // Pin pair and pulse shapes
  inv_pin_a: assert property (timer_output_inverted_pin == ~timer_output_pin)
    else $error("inverted pin differs");
  a_pulse_a: assert property (match_a_irq |=> !match_a_irq)
    else $error("match a pulse too long");
  p_pulse_a: assert property (match_p_irq |=> !match_p_irq)
    else $error("match p pulse too long");
  idle_irq_a: assert property (!counter_enable_bit && !$past(counter_enable_bit)
    |-> !(match_a_irq || match_p_irq))
    else $error("irq while counter off");
  // Read data holds between reads; high bytes carry two bits only
  rd_hold_a: assert property (!byte_read |=> $stable(byte_rdata))
    else $error("read data moved");
  hi_read_a: assert property (byte_read && byte_addr[0] |=> byte_rdata[7:2] == 6'h00)
    else $error("high byte upper bits set");
  // Compare output actions; four cycles cover the enable rise load
  still_pin_a: assert property ((cmp_mode && output_function == 2'h0 && counter_enable_bit
    && $stable(output_polarity))[*4] |-> $stable(timer_output_pin))
    else $error("pin moved with no action");
  tog_pin_a: assert property (match_a_irq && cmp_mode && output_function == 2'h3
    |-> timer_output_pin != $past(timer_output_pin))
    else $error("pin did not toggle");
  set_pin_a: assert property (match_a_irq && cmp_mode && output_function inside {2'h1, 2'h2}
    |-> timer_output_pin == (output_polarity ^ output_function[1]))
    else $error("pin level wrong on match");
  init_pin_a: assert property ($rose(counter_enable_bit) && cmp_mode
    |-> ##[1:2] timer_output_pin == (output_initial_level ^ output_polarity))
    else $error("initial level not loaded");
  // Main scenarios
  cover property (match_a_irq);
  cover property (match_p_irq);
  cover property (byte_read && byte_addr == 2'h3);
endmodule : tmc_core_monitor

// ===== tb/tmc_clk_model.sv
// Far side model: enable pulses of the high clock and the sub clock
`timescale 1ns/1ps
module tmc_clk_model (
  input wire logic clock,
  input wire logic resetn,
  output logic internal_high_clock,
  output logic sub_clock
);
  logic hi_q;
  logic [1:0] sub_q;
  // Different rates keep the divider periods apart from each other
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hi_q <= 1'b0;
      sub_q <= 2'h0;
    end else begin
      hi_q <= !hi_q;
      sub_q <= (sub_q == 2'h2) ? 2'h0 : sub_q + 2'h1;
    end
  end
  // High clock every second cycle, sub clock every third
  assign internal_high_clock = hi_q;
  assign sub_clock = sub_q == 2'h2;
endmodule : tmc_clk_model

// ===== tb/tmc_core_tb_top.sv
// Self-checking testbench for the timer core
`timescale 1ns/1ps
module tmc_core_tb_top;
  logic clock, resetn, counter_enable_bit, counter_pause, output_initial_level, output_polarity;
  logic clear_on_a_match, ext_clock_pin, capture_input_pin, byte_write, byte_read, single_pulse_mode;
  logic [2:0] clock_source_select, compare_p_value;
  logic [1:0] timer_mode, output_function, capture_edge_select, byte_addr;
  logic [7:0] byte_wdata, byte_rdata;
  logic match_a_irq, match_p_irq, timer_output_pin, timer_output_inverted_pin, internal_high_clock, sub_clock;
  logic [15:0] v;
  int n_mismatch, n_compared, n, hits, h0;
  int unsigned a_val, k;
  int mult [6] = '{4, 1, 32, 128, 3, 3};

  tmc_core i_tmc_core (.clock, .resetn, .counter_enable_bit, .counter_pause, .clock_source_select,
    .compare_p_value, .timer_mode, .output_function, .output_initial_level, .output_polarity,
    .clear_on_a_match, .single_pulse_mode, .capture_edge_select, .internal_high_clock, .sub_clock,
    .ext_clock_pin, .capture_input_pin, .byte_write, .byte_read, .byte_addr, .byte_wdata, .byte_rdata,
    .match_a_irq, .match_p_irq, .timer_output_pin, .timer_output_inverted_pin);
  tmc_clk_model i_tmc_clk_model (.clock, .resetn, .internal_high_clock, .sub_clock);

  // Free-running 125 MHz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic test_done;
    $display("Mismatches %0d, compares %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic cmp_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : cmp_val

  // One strobe cycle, then an idle edge so read data has landed
  task automatic bus(input logic wr, input logic [1:0] addr, input logic [7:0] data);
    byte_write <= wr;
    byte_read <= !wr;
    byte_addr <= addr;
    byte_wdata <= data;
    @(posedge clock);
    byte_write <= 1'b0;
    byte_read <= 1'b0;
    @(posedge clock);
  endtask : bus

  // high byte first, so the buffer holds the matching low byte
  task automatic rd16(input logic [1:0] hi_addr, input logic [1:0] lo_addr);
    bus(1'b0, hi_addr, 8'h00);
    v[15:8] = byte_rdata;
    bus(1'b0, lo_addr, 8'h00);
    v[7:0] = byte_rdata;
  endtask : rd16

  task automatic wait_irq(input logic p, input int lim);
    n = 0;
    do begin
      @(posedge clock);
      n++;
      if (n > lim) begin
        n_mismatch++;
        $display("BAD irq wait expected pulse seen none");
        test_done();
      end
    end while ((p ? match_p_irq : match_a_irq) !== 1'b1);
  endtask : wait_irq

  task automatic restart;
    counter_enable_bit <= 1'b0;
    @(posedge clock);
    counter_enable_bit <= 1'b1;
  endtask : restart

  initial begin
    {counter_enable_bit, counter_pause, output_initial_level, output_polarity, clear_on_a_match} = 5'h00;
    {ext_clock_pin, capture_input_pin, byte_write, byte_read, resetn, single_pulse_mode} = 6'h00;
    {timer_mode, output_function, capture_edge_select, byte_addr} = 8'h00;
    clock_source_select = 3'h1;
    compare_p_value = 3'h0;
    byte_wdata = 8'h00;
    n_mismatch = 0;
    n_compared = 0;
    k = $urandom(32'h5907);
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    // Clock sources 0 to 5: match period is A plus one ticks
    clear_on_a_match <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      a_val = 4 + $urandom_range(16);
      counter_enable_bit <= 1'b0;
      clock_source_select <= i[2:0];
      output_function <= 2'(i % 3 + 1);
      bus(1'b1, 2'h2, a_val[7:0]);
      bus(1'b1, 2'h3, 8'h00);
      counter_enable_bit <= 1'b1;
      wait_irq(1'b0, 3000);
      wait_irq(1'b0, 3000);
      cmp_val("match period", 16'((a_val + 1) * mult[i]), 16'(n));
    end
    // Pin edges counted on either edge; enable rise clears the count
    clear_on_a_match <= 1'b0;
    output_function <= 2'h0;
    for (int i = 6; i < 8; i++) begin
      clock_source_select <= i[2:0];
      k = $urandom_range(300, 200);
      restart();
      repeat (k) begin
        repeat (2) @(posedge clock);
        ext_clock_pin <= 1'b1;
        repeat (2) @(posedge clock);
        ext_clock_pin <= 1'b0;
      end
      repeat (6) @(posedge clock);
      bus(1'b1, 2'h1, 8'hff);
      rd16(2'h1, i[0] ? 2'h2 : 2'h0);
      cmp_val("counter", 16'(k), v);
    end
    // Low byte write alone leaves compare A as it was
    bus(1'b1, 2'h2, ~a_val[7:0]);
    rd16(2'h3, 2'h2);
    cmp_val("compare a kept", 16'(a_val), v);
    a_val = 10 + $urandom_range(90);
    bus(1'b1, 2'h2, a_val[7:0]);
    bus(1'b1, 2'h3, 8'h00);
    // PWM duty against both polarities, period set by P
    clock_source_select <= 3'h1;
    compare_p_value <= 3'h1;
    timer_mode <= 2'h2;
    output_function <= 2'h2;
    for (int pol = 0; pol < 2; pol++) begin
      output_polarity <= pol[0];
      restart();
      wait_irq(1'b1, 1100);
      hits = 0;
      n = 0;
      do begin
        @(posedge clock);
        n++;
        hits += (timer_output_pin === 1'b1);
      end while (match_p_irq !== 1'b1 && n < 300);
      cmp_val("pwm period end", 16'h0001, 16'(match_p_irq === 1'b1));
      if (pol == 0) begin
        h0 = hits;
      end
    end
    cmp_val("pwm polarity", 16'(n - h0), 16'(hits));
    cmp_val("pwm duty", 16'h0001, 16'(h0 == a_val || n - h0 == a_val));
    // Capture on rise, fall and both edges
    timer_mode <= 2'h1;
    counter_pause <= 1'b1;
    restart();
    for (int c = 0; c < 3; c++) begin
      capture_edge_select <= c[1:0];
      @(posedge clock);
      for (int e = 0; e < 2; e++) begin
        capture_input_pin <= !e[0];
        hits = 0;
        repeat (8) begin
          @(posedge clock);
          hits += (match_a_irq === 1'b1);
        end
        cmp_val("capture", 16'(c != 1 - e), 16'(hits));
      end
    end
    // Single pulse: pin rise starts it, compare A match ends it after A ticks
    timer_mode <= 2'h3;
    counter_pause <= 1'b0;
    output_polarity <= 1'b0;
    clock_source_select <= 3'h1;
    single_pulse_mode <= 1'b1;
    a_val = 5 + $urandom_range(40);
    bus(1'b1, 2'h2, a_val[7:0]);
    bus(1'b1, 2'h3, 8'h00);
    restart();
    repeat (10) @(posedge clock);
    ext_clock_pin <= 1'b1;
    hits = 0;
    repeat (100) begin
      @(posedge clock);
      hits += (timer_output_pin === 1'b1);
    end
    cmp_val("single pulse", 16'(a_val), 16'(hits));
    test_done();
  end
endmodule : tmc_core_tb_top

bind tmc_core tmc_core_monitor i_tmc_core_monitor (.clock, .resetn, .counter_enable_bit, .output_initial_level,
  .output_polarity, .timer_mode, .output_function, .byte_read, .byte_addr, .byte_rdata, .match_a_irq,
  .match_p_irq, .timer_output_pin, .timer_output_inverted_pin);
